// ### scs_sequencer.sv
/*
 * conversion sequencer of a 14-bit charge-redistribution converter:
 * acquisition timing, msb-first bit trials, code forming, mode and range
 * selection, a result fifo and an axi4-lite register slave.
 * assumes: all pins synchronous to mclk; compAbove is the comparator,
 * high when the held sample is at or above the trial level.
 */
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "scs_regs.svh"

// Overview of operation
// - start only after acquisition and start falling
// - trial bits msb first, halving weights
// - form code, then drop busy
// - fast high, low-power low: warp mode
// - equal selects give normal mode
// - low-power mode powers down after conversion
// - new config taken after one acquisition
// - register config ignores mode pins
// - four input ranges, pins or register
// - straight binary code points
// - twos complement code points
// - overrange saturates to top or bottom
// - result belongs to just-finished conversion
// - range from bipolar and ten-volt pins, or from their control bits in register config
module scs_sequencer
   import scs_pkg::*;
#(
   parameter logic [16:0] GAP_CYC = 17'(`SCS_WARP_GAP_CYC)
) (
   input  wire logic                   mclk,
   input  wire logic                   reset_n,
   input  wire logic                   convert_start_n,
   input  wire logic                   fast_mode_sel,
   input  wire logic                   low_power_mode_sel,
   input  wire logic                   coding_select,
   input  wire logic                   bipolar_sel,
   input  wire logic                   ten_volt_sel,
   input  wire logic                   compAbove,
   input  wire logic                   overPos,
   input  wire logic                   overNeg,
   output logic                        busy,
   output logic                        sampleEn,
   output logic                        powerDown,
   output logic [13:0]                 dacTrial,
   output scs_cfg_t                    activeCfg,
   input  wire logic [`SCS_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [`SCS_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready
);
   scs_state_t                state_r;
   logic [`SCS_CTRL_W-1:0]    ctrl_r;
   logic [4:0]                acqCnt_r;
   logic [3:0]                bitIdx_r;
   logic [16:0]               gapCnt_r;
   logic                      cnvPrev_r;
   logic                      satPos_r;
   logic                      satNeg_r;
   logic                      stale_r;
   logic                      lastStale_r;
   logic [`SCS_ADDR_W-1:0]    awAddr_r;
   logic [31:0]               wData_r;
   logic                      wByte0_r;
   logic                      awHeld_r;
   logic                      wHeld_r;
   logic                      acqDone;
   logic                      startFall;
   logic                      startOk;
   logic                      tick;
   logic                      wrGo;
   logic                      rdGo;
   logic [13:0]               bitMask;
   logic [13:0]               trialKeep;
   logic [3:0]                bitPeriod;
   scs_cfg_t                  effCfg;
   scs_result_t               fifoIn;
   scs_result_t               fifoOut;
   logic                      fifoInReady;
   logic                      fifoOutValid;
   logic                      fifoPop;
   logic [3:0]                fifoLevel;

   // ----------------------------------------
   // configuration selection
   // ----------------------------------------
   function automatic scs_mode_t modeOf(input logic fast, input logic lowPwr);
      if (fast && !lowPwr)
         return SCS_WARP;
      else if (!fast && lowPwr)
         return SCS_IMPULSE;
      return SCS_NORMAL;
   endfunction : modeOf

   always_comb begin
      if (ctrl_r[`SCS_CTRL_SWCFG]) begin
         effCfg.mode    = modeOf(ctrl_r[`SCS_CTRL_FAST], ctrl_r[`SCS_CTRL_LOWPWR]);
         effCfg.twos    = !ctrl_r[`SCS_CTRL_BINARY];
         effCfg.bipolar = ctrl_r[`SCS_CTRL_BIPOLAR];
         effCfg.tenVolt = ctrl_r[`SCS_CTRL_TEN];
      end else begin
         effCfg.mode    = modeOf(fast_mode_sel, low_power_mode_sel);
         effCfg.twos    = !coding_select;
         effCfg.bipolar = bipolar_sel;
         effCfg.tenVolt = ten_volt_sel;
      end
   end

   // bit period per mode; warp is shortest so it alone reaches 1 msps
   always_comb begin
      unique case (activeCfg.mode)
         SCS_WARP:    bitPeriod = 4'(`SCS_BIT_CYC(`SCS_WARP_PER_NS));
         SCS_IMPULSE: bitPeriod = 4'(`SCS_BIT_CYC(`SCS_IMP_PER_NS));
         default:     bitPeriod = 4'(`SCS_BIT_CYC(`SCS_NORM_PER_NS));
      endcase
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   assign acqDone   = acqCnt_r == 5'(`SCS_ACQ_CYC);
   assign startFall = cnvPrev_r && !convert_start_n;
   assign startOk   = state_r == ST_ACQ && acqDone && startFall;
   assign bitMask   = 14'h0001 << bitIdx_r;
   assign trialKeep = compAbove ? dacTrial : (dacTrial & ~bitMask);

   scs_clk_div u_div (
      .mclk    (mclk),
      .reset_n (reset_n),
      .run     (state_r == ST_CONV),
      .period  (bitPeriod),
      .tick    (tick)
   );

   // start edge detector
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         cnvPrev_r <= 1'b1;
      else
         cnvPrev_r <= convert_start_n;
   end

   // acquisition timer, restarts when each conversion ends
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         acqCnt_r <= 5'h00;
      else if (state_r != ST_ACQ)
         acqCnt_r <= 5'h00;
      else if (!acqDone)
         acqCnt_r <= acqCnt_r + 5'h01;
   end

   // main state, trials and busy; edges outside acq fall through
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_r   <= ST_ACQ;
         bitIdx_r  <= 4'h0;
         dacTrial  <= 14'h0000;
         busy      <= 1'b0;
         sampleEn  <= 1'b1;
         powerDown <= 1'b0;
         activeCfg <= '0;
         satPos_r  <= 1'b0;
         satNeg_r  <= 1'b0;
      end else begin
         unique case (state_r)
            ST_ACQ: if (startOk) begin
               activeCfg <= effCfg;
               satPos_r  <= overPos;
               satNeg_r  <= overNeg;
               dacTrial  <= `SCS_TRIAL_MSB;
               bitIdx_r  <= 4'hd;
               busy      <= 1'b1;
               sampleEn  <= 1'b0;
               powerDown <= 1'b0;
               state_r   <= ST_CONV;
            end
            ST_CONV: if (tick) begin
               if (bitIdx_r == 4'h0) begin
                  dacTrial <= trialKeep;
                  state_r  <= ST_FORM;
               end else begin
                  dacTrial <= trialKeep | (bitMask >> 1);
                  bitIdx_r <= bitIdx_r - 4'h1;
               end
            end
            ST_FORM: if (fifoInReady) begin
               busy      <= 1'b0;
               sampleEn  <= 1'b1;
               powerDown <= activeCfg.mode == SCS_IMPULSE;
               state_r   <= ST_ACQ;
            end
            default: state_r <= ST_ACQ;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         gapCnt_r <= 17'h1ffff;
         stale_r  <= 1'b0;
      end else if (startOk) begin
         gapCnt_r <= 17'h00000;
         stale_r  <= effCfg.mode == SCS_WARP && gapCnt_r >= GAP_CYC;
      end else if (gapCnt_r < GAP_CYC) begin
         gapCnt_r <= gapCnt_r + 17'h00001;
      end
   end

   // ----------------------------------------
   // code forming and result fifo
   // ----------------------------------------
   always_comb begin
      fifoIn.stale = stale_r;
      fifoIn.sat   = satPos_r || satNeg_r;
      if (satPos_r)
         fifoIn.code = `SCS_CODE_TOP;
      else if (satNeg_r)
         fifoIn.code = `SCS_CODE_BOTTOM;
      else
         // straight binary is the raw code
         fifoIn.code = dacTrial;
      if (activeCfg.twos)
         fifoIn.code[13] = !fifoIn.code[13];
   end

   // pushed in the cycle busy falls
   scs_fifo #(.W($bits(scs_result_t)), .DEPTH(`SCS_FIFO_DEPTH)) u_fifo (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .inData   (fifoIn),
      .inValid  (state_r == ST_FORM),
      .inReady  (fifoInReady),
      .outData  (fifoOut),
      .outValid (fifoOutValid),
      .outReady (fifoPop),
      .level    (fifoLevel)
   );

   // ----------------------------------------
   // axi4-lite slave
   // ----------------------------------------
   assign wrGo    = awHeld_r && wHeld_r && !s_axi_bvalid;
   assign rdGo    = s_axi_arvalid && s_axi_arready;
   assign fifoPop = rdGo && s_axi_araddr == `SCS_OFF_RESULT && fifoOutValid;

   // address and data taken in either order
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         awHeld_r      <= 1'b0;
         wHeld_r       <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         awAddr_r      <= '0;
         wData_r       <= 32'h0000_0000;
         wByte0_r      <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r      <= 1'b1;
            awAddr_r      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else begin
            if (wrGo)
               awHeld_r <= 1'b0;
            s_axi_awready <= !awHeld_r && !s_axi_bvalid;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r      <= 1'b1;
            wData_r      <= s_axi_wdata;
            wByte0_r     <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end else begin
            if (wrGo)
               wHeld_r <= 1'b0;
            s_axi_wready <= !wHeld_r && !s_axi_bvalid;
         end
      end
   end

   // write response and control register; range settable any time
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r       <= `SCS_CTRL_RST;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `SCS_RESP_OKAY;
      end else if (wrGo) begin
         s_axi_bvalid <= 1'b1;
         if (awAddr_r == `SCS_OFF_CTRL) begin
            s_axi_bresp <= `SCS_RESP_OKAY;
            if (wByte0_r)
               ctrl_r <= wData_r[`SCS_CTRL_W-1:0];
         end else if (awAddr_r == `SCS_OFF_STATUS || awAddr_r == `SCS_OFF_RESULT) begin
            s_axi_bresp <= `SCS_RESP_OKAY;
         end else begin
            s_axi_bresp <= `SCS_RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // reads; a result read pops the fifo, an empty one reads zero
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `SCS_RESP_OKAY;
         lastStale_r   <= 1'b0;
      end else if (rdGo) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= `SCS_RESP_OKAY;
         s_axi_rdata   <= 32'h0000_0000;
         unique case (s_axi_araddr)
            `SCS_OFF_CTRL:   s_axi_rdata[`SCS_CTRL_W-1:0] <= ctrl_r;
            `SCS_OFF_STATUS: begin
               s_axi_rdata[`SCS_STAT_BUSY]  <= busy;
               s_axi_rdata[`SCS_STAT_VALID] <= fifoOutValid;
               s_axi_rdata[`SCS_STAT_STALE] <= lastStale_r;
               s_axi_rdata[`SCS_STAT_LVL_LO +: 4] <= fifoLevel;
            end
            `SCS_OFF_RESULT: if (fifoOutValid) begin
               s_axi_rdata[15:0] <= fifoOut;
               lastStale_r       <= fifoOut.stale;
            end
            default: s_axi_rresp <= `SCS_RESP_SLVERR;
         endcase
      end else if (s_axi_rvalid) begin
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   sequence seqStart;
      state_r == ST_ACQ && acqDone && startFall;
   endsequence

   chk_start_gate: assert property ((state_r == ST_ACQ && startFall && !acqDone) |=> !busy)
      else $error("start taken before acquisition done");
   chk_msb_first: assert property (seqStart |=> busy && dacTrial == 14'h2000 && bitIdx_r == 4'hd)
      else $error("first trial is not the msb");
   chk_trial_halve: assert property ((state_r == ST_CONV && tick && bitIdx_r != 4'h0) |=>
      dacTrial[bitIdx_r] && (dacTrial & ((14'h0001 << bitIdx_r) - 14'h0001)) == 14'h0000)
      else $error("next trial weight not half");
   chk_busy_release: assert property ($fell(busy) |-> $past(state_r == ST_FORM && fifoInReady))
      else $error("busy fell without storing a code");
   chk_warp_period: assert property ((seqStart and (effCfg.mode == SCS_WARP)) |=> bitPeriod == 4'h4)
      else $error("warp bit period wrong");
   chk_normal_mode: assert property ((seqStart and (!ctrl_r[`SCS_CTRL_SWCFG]
      && fast_mode_sel == low_power_mode_sel)) |=> activeCfg.mode == SCS_NORMAL)
      else $error("equal selects not normal mode");
   chk_impulse_pd: assert property ((state_r == ST_FORM && fifoInReady
      && activeCfg.mode == SCS_IMPULSE) |=> powerDown && !busy)
      else $error("no power down after impulse conversion");
   chk_cfg_take: assert property (seqStart |=> activeCfg == $past(effCfg))
      else $error("config not taken at start");
   chk_sw_ignore: assert property ((seqStart and ctrl_r[`SCS_CTRL_SWCFG]) |=>
      activeCfg.tenVolt == ctrl_r[`SCS_CTRL_TEN] && activeCfg.bipolar == ctrl_r[`SCS_CTRL_BIPOLAR])
      else $error("pins used in register config");
   chk_code_sat: assert property ((state_r == ST_FORM && satPos_r) |->
      fifoIn.code == (activeCfg.twos ? 14'h1fff : 14'h3fff))
      else $error("positive overrange not saturated");
   chk_code_twos: assert property ((state_r == ST_FORM && !fifoIn.sat && activeCfg.twos) |->
      fifoIn.code == {!dacTrial[13], dacTrial[12:0]})
      else $error("twos complement code wrong");
   chk_busy_hold: assert property ((busy && startFall) |=> busy [*4])
      else $error("start edge disturbed running conversion");
endmodule : scs_sequencer

// ### scs_regs.svh
/*
 * register offsets, field positions, reset values and timing counts
 * of the conversion sequencer.
 * assumes: included by bare name; mclk at 100 MHz.
 */
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH

// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define SCS_ADDR_W       4
`define SCS_OFF_CTRL     4'h0
`define SCS_OFF_STATUS   4'h4
`define SCS_OFF_RESULT   4'h8

// ----------------------------------------
// control fields
// ----------------------------------------
`define SCS_CTRL_SWCFG   0
`define SCS_CTRL_FAST    1
`define SCS_CTRL_LOWPWR  2
`define SCS_CTRL_BINARY  3
`define SCS_CTRL_BIPOLAR 4
`define SCS_CTRL_TEN     5
`define SCS_CTRL_W       6
`define SCS_CTRL_RST     6'h00

// ----------------------------------------
// status fields
// ----------------------------------------
`define SCS_STAT_BUSY    0
`define SCS_STAT_VALID   1
`define SCS_STAT_STALE   2
`define SCS_STAT_LVL_LO  3

// ----------------------------------------
// bus answers and code points
// ----------------------------------------
`define SCS_RESP_OKAY    2'h0
`define SCS_RESP_SLVERR  2'h2
`define SCS_TRIAL_MSB    14'h2000
`define SCS_CODE_TOP     14'h3fff
`define SCS_CODE_BOTTOM  14'h0000
`define SCS_FIFO_DEPTH   8

// ----------------------------------------
// timing
// ----------------------------------------
`define SCS_CLK_MHZ      100
`define SCS_ACQ_NS       250
`define SCS_ACQ_CYC      ((`SCS_ACQ_NS * `SCS_CLK_MHZ + 999) / 1000)
`define SCS_WARP_PER_NS  1000
`define SCS_NORM_PER_NS  1250
`define SCS_IMP_PER_NS   1493
`define SCS_BIT_CYC(p)   (((p) * `SCS_CLK_MHZ / 1000 - `SCS_ACQ_CYC) / 16)
`define SCS_WARP_GAP_US  1000
`define SCS_WARP_GAP_CYC (`SCS_WARP_GAP_US * `SCS_CLK_MHZ)

`endif

// ### scs_pkg.sv
/*
 * types shared by the conversion sequencer files.
 * assumes: nothing beyond the compiler.
 */
package scs_pkg;

   // speed and power modes
   typedef enum logic [1:0] {
      SCS_WARP    = 2'b00,
      SCS_NORMAL  = 2'b01,
      SCS_IMPULSE = 2'b10
   } scs_mode_t;

   // sequencer states
   typedef enum logic [1:0] {
      ST_ACQ  = 2'b00,
      ST_CONV = 2'b01,
      ST_FORM = 2'b10
   } scs_state_t;

   // configuration applied to one conversion
   typedef struct packed {
      logic      bipolar;
      logic      tenVolt;
      logic      twos;
      scs_mode_t mode;
   } scs_cfg_t;

   // one finished result as stored in the fifo
   typedef struct packed {
      logic        stale;
      logic        sat;
      logic [13:0] code;
   } scs_result_t;

endpackage : scs_pkg

// ### scs_clk_div.sv
/*
 * bit-trial rate divider: one-cycle tick every period cycles.
 * assumes: period stays fixed while run is high; period >= 1.
 */
`timescale 1ns/1ps
module scs_clk_div (
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic       run,
   input  wire logic [3:0] period,
   output logic            tick
);
   logic [3:0] cnt_r;

   // ----------------------------------------
   // counter, held at zero while idle
   // ----------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= 4'h0;
         tick  <= 1'b0;
      end else if (!run) begin
         cnt_r <= 4'h0;
         tick  <= 1'b0;
      end else if (cnt_r == period - 4'h1) begin
         cnt_r <= 4'h0;
         tick  <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 4'h1;
         tick  <= 1'b0;
      end
   end
endmodule : scs_clk_div

// ### scs_fifo.sv
/*
 * small result fifo with registered read data (show-ahead).
 * assumes: DEPTH is a power of two.
 */
`timescale 1ns/1ps
module scs_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 8
) (
   input  wire logic                       mclk,
   input  wire logic                       reset_n,
   input  wire logic [W-1:0]               inData,
   input  wire logic                       inValid,
   output logic                            inReady,
   output logic [W-1:0]                    outData,
   output logic                            outValid,
   input  wire logic                       outReady,
   output logic [$clog2(DEPTH+1)-1:0]      level
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wrPtr_r;
   logic [AW-1:0] rdPtr_r;
   logic [AW-1:0] rdNext;
   logic          push;
   logic          pop;

   // honest flags straight from the count
   assign inReady  = level != ($clog2(DEPTH+1))'(DEPTH);
   assign outValid = level != '0;
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;
   assign rdNext   = rdPtr_r + AW'(pop);

   // ----------------------------------------
   // pointers and fill level
   // ----------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         level   <= '0;
      end else begin
         wrPtr_r <= wrPtr_r + AW'(push);
         rdPtr_r <= rdNext;
         level   <= level + ($clog2(DEPTH+1))'(push) - ($clog2(DEPTH+1))'(pop);
      end
   end

   // storage; a write into an empty fifo bypasses into the head register
   always_ff @(posedge mclk) begin
      if (push)
         mem[wrPtr_r] <= inData;
      outData <= (push && wrPtr_r == rdNext) ? inData : mem[rdNext];
   end
endmodule : scs_fifo

// ### scs_analog_model.sv
/* analog front end stand-in: holds the sample, answers trials.
   assumes: level is steady while sampleEn is high. */
`timescale 1ns/1ps
module scs_analog_model (
   input  wire logic        mclk,
   input  wire logic        sampleEn,
   input  wire logic [13:0] level,
   input  wire logic [13:0] dacTrial,
   output logic             compAbove
);
   logic [13:0] held_r;
   always_ff @(posedge mclk) begin
      if (sampleEn) held_r <= level;
   end
   // comparator, no offset modelled
   assign compAbove = (held_r >= dacTrial);
endmodule : scs_analog_model

// ### test_sar_conversion_sequencer.sv
/* bench for the conversion sequencer: corner and random conversions.
   assumes: scs_pkg, scs_regs.svh and the analog model come first. */
`timescale 1ns/1ps
`include "scs_regs.svh"
module test_sar_conversion_sequencer import scs_pkg::*;;
   logic mclk = 0, rstN = 0, cnvN = 1, fast = 0, lowPwr = 0, codSel = 0;
   logic bip = 0, ten = 0, opos = 0, oneg = 0, comp, busy, smpEn, pwrDn;
   logic [13:0] dac, lvl = 0;
   scs_cfg_t cfg;
   logic [3:0] awA = 0, arA = 0;
   logic [31:0] wD = 0, rData, r, d;
   logic awV = 0, wV = 0, bR = 0, arV = 0, rR = 0, awRdy, wRdy, bV, arRdy, rV, b;
   logic [1:0] bRsp, rRsp, rsp;
   int miscompares = 0, checked = 0, cyc = 0, seed = 27601, i, lastSt = -100000;
   logic st;
   localparam int GAP = 200;

   always #5 mclk = ~mclk;

   scs_sequencer #(.GAP_CYC(17'(GAP))) uut (.mclk(mclk), .reset_n(rstN), .convert_start_n(cnvN),
      .fast_mode_sel(fast), .low_power_mode_sel(lowPwr), .coding_select(codSel), .bipolar_sel(bip),
      .ten_volt_sel(ten), .compAbove(comp), .overPos(opos), .overNeg(oneg), .busy(busy),
      .sampleEn(smpEn), .powerDown(pwrDn), .dacTrial(dac), .activeCfg(cfg), .s_axi_awaddr(awA),
      .s_axi_awvalid(awV), .s_axi_awready(awRdy), .s_axi_wdata(wD), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wV), .s_axi_wready(wRdy), .s_axi_bresp(bRsp), .s_axi_bvalid(bV),
      .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arRdy),
      .s_axi_rdata(rData), .s_axi_rresp(rRsp), .s_axi_rvalid(rV), .s_axi_rready(rR));

   scs_analog_model afe (.mclk(mclk), .sampleEn(smpEn), .level(lvl), .dacTrial(dac), .compAbove(comp));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask : chk

   task tally_and_finish;
      $display("checks %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   // bus write: hold each channel until its own ready
   task wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge mclk);
      awA <= a;
      wD <= v;
      awV <= 1;
      wV <= 1;
      bR <= 1;
      do begin
         @(posedge mclk);
         if (awRdy) awV <= 0;
         if (wRdy) wV <= 0;
      end while (bV !== 1'b1);
      bR <= 0;
      chk(bRsp, `SCS_RESP_OKAY, "write response");
   endtask : wr

   task rd(input logic [3:0] a);
      @(posedge mclk);
      arA <= a;
      arV <= 1;
      rR <= 1;
      do begin
         @(posedge mclk);
         if (arRdy) arV <= 0;
      end while (rV !== 1'b1);
      d = rData;
      rsp = rRsp;
      rR <= 0;
   endtask : rd

   // expected code: saturation first, then coding
   function logic [13:0] expc(logic [13:0] s, logic bin, logic op, logic on);
      logic [13:0] c;
      c = op ? 14'h3fff : on ? 14'h0000 : s;
      return bin ? c : c ^ 14'h2000;
   endfunction : expc

   function scs_mode_t expm(logic f, logic l);
      return (f && !l) ? SCS_WARP : (!f && l) ? SCS_IMPULSE : SCS_NORMAL;
   endfunction : expm

   // one conversion with a stray start edge while busy
   task conv(input logic [13:0] s, input logic bin, input scs_cfg_t c);
      int n;
      lvl <= s;
      repeat (30) @(posedge mclk);
      cnvN <= 0;
      // warp start after a long gap is stale
      st = c.mode == SCS_WARP && cyc - lastSt > GAP;
      lastSt = cyc;
      repeat (3) @(posedge mclk);
      chk(busy, 1, "busy after start");
      chk(smpEn, 0, "sample held during conversion");
      chk(cfg, c, "latched config");
      cnvN <= 1;
      @(posedge mclk);
      cnvN <= 0;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (busy !== 1'b0 && n < 400);
      cnvN <= 1;
      rd(`SCS_OFF_STATUS);
      chk(d[6:3], 1, "one result queued");
      rd(`SCS_OFF_RESULT);
      chk(d[13:0], expc(s, bin, opos, oneg), "result code");
      chk(d[15:14], {st, opos || oneg}, "stale and overrange flags");
      chk(pwrDn, c.mode == SCS_IMPULSE, "power down");
   endtask : conv

   // hang guard, well above the expected run
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         tally_and_finish;
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge mclk);
      rstN <= 1;
      @(posedge mclk);
      cnvN <= 0;
      repeat (4) @(posedge mclk);
      chk(busy, 0, "early start ignored");
      cnvN <= 1;
      for (i = 0; i < 24; i++) begin
         r = $random(seed);
         b = (i < 10) ? i[0] : r[14];
         codSel <= b;
         fast <= r[15];
         lowPwr <= r[16];
         bip <= r[17];
         ten <= r[18];
         opos <= (i == 6 || i == 7);
         oneg <= (i == 8 || i == 9);
         conv((i < 2) ? 14'h0000 : (i < 4) ? 14'h2000 : (i < 6) ? 14'h3fff : r[13:0],
              b, scs_cfg_t'{r[17], r[18], ~b, expm(r[15], r[16])});
      end
      fast <= 1;
      lowPwr <= 0;
      codSel <= 0;
      // long idle before a warp conversion
      repeat (300) @(posedge mclk);
      conv(14'h0abc, 0, scs_cfg_t'{bip, ten, 1'b1, SCS_WARP});
      wr(`SCS_OFF_CTRL, 32'h3d);
      conv(14'h1234, 1, scs_cfg_t'{1'b1, 1'b1, 1'b0, SCS_IMPULSE});
      wr(`SCS_OFF_CTRL, 32'h0);
      rd(4'hc);
      chk(rsp, `SCS_RESP_SLVERR, "unmapped address");
      tally_and_finish;
   end
endmodule : test_sar_conversion_sequencer
